/* pkg/otsup_pkg.sv */
// Package of constants, types and register map for the overtravel supervisor
//
// Summary of operation
// - Direction select 0 means CCW forward, 1 means CW forward.
// - Direction select never changes polarity of any output signal.
// - Forward limit input OFF prohibits forward running and flags forward overtravel.
// - Reverse limit input OFF prohibits reverse running and flags reverse overtravel.
// - During overtravel, motion in the opposite direction stays allowed.
// - Forward limit enable: 1 uses the input, 8 ignores it; applied at restart.
// - Reverse limit enable: 2 uses the input, 8 ignores it; applied at restart.
// - Stop setting picks stop action and post-stop mode; applied at restart.
// - Second digit 1 decelerates, then holds the motor in zero clamp.
// - Zero clamp closes a position loop on a zero position reference.
// - Under torque control no deceleration stop; brake or coast, then coast.
// - Emergency stop torque 0 to 800 percent, default 800, applies immediately.
// - With detection enabled, overtravel during servo power on raises the warning.
// - Warning detection enabled only when digit four of warning config is 1.
// - Even a brief overtravel pulse is caught and latched as a warning.
// - With a reference, overtravel in the reference direction raises the warning.
// - Overtravel opposite to the reference raises no warning.
// - With no reference, overtravel on either side raises the warning.
// - No warning while servo power is off.
// - Servo power turning on during existing overtravel raises no warning.
// - Clear command always clears; warning suppressed until overtravel clears and recurs.
// - Active software limit counts as overtravel for the warning.
package otsup_pkg;

   // -------------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------------
   localparam logic [7:0] OTSUP_ADDR_CFG    = 8'h00;
   localparam logic [7:0] OTSUP_ADDR_ESTOP  = 8'h04;
   localparam logic [7:0] OTSUP_ADDR_CTRL   = 8'h08;
   localparam logic [7:0] OTSUP_ADDR_STATUS = 8'h0c;

   // -------------------------------------------------------------------
   // Configuration register field positions (one nibble per setting, two for the stop setting)
   // -------------------------------------------------------------------
   localparam int OTSUP_CFG_DIR_LSB   = 0;
   localparam int OTSUP_CFG_FWDEN_LSB = 4;
   localparam int OTSUP_CFG_REVEN_LSB = 8;
   localparam int OTSUP_CFG_STOP_LSB  = 12;
   localparam int OTSUP_CFG_WARN_LSB  = 20;

   // Settings values
   localparam logic [3:0] OTSUP_FWD_USE_INPUT = 4'h1;
   localparam logic [3:0] OTSUP_REV_USE_INPUT = 4'h2;
   localparam logic [3:0] OTSUP_LIMIT_IGNORE  = 4'h8;
   localparam logic [3:0] OTSUP_WARN_ENABLE   = 4'h1;

   // Reset values
   localparam logic [31:0] OTSUP_CFG_RST   = 32'h0000_0210;
   localparam logic [9:0]  OTSUP_ESTOP_RST = 10'h320;
   localparam logic [9:0]  OTSUP_ESTOP_MAX = 10'h320;

   // Control register bits (write-only pulses)
   localparam int OTSUP_CTRL_CLR_BIT = 0;
   localparam int OTSUP_CTRL_RST_BIT = 1;

   // Status register bit positions
   localparam int OTSUP_ST_FWD_OT   = 0;
   localparam int OTSUP_ST_REV_OT   = 1;
   localparam int OTSUP_ST_FWD_OK   = 2;
   localparam int OTSUP_ST_REV_OK   = 3;
   localparam int OTSUP_ST_WARN     = 4;
   localparam int OTSUP_ST_ZCLAMP   = 5;
   localparam int OTSUP_ST_STOP_LSB = 8;
   localparam int OTSUP_ST_CCWFWD   = 12;

   // AXI responses
   localparam logic [1:0] OTSUP_RESP_OKAY   = 2'h0;
   localparam logic [1:0] OTSUP_RESP_SLVERR = 2'h2;

   // Stop action encoding
   typedef enum logic [1:0] {
      OTSUP_STOP_DB    = 2'h0,
      OTSUP_STOP_COAST = 2'h1,
      OTSUP_STOP_DECEL = 2'h3
   } otsup_stop_t;

   // Warning detector phase: armed, latched, suppressed after clear
   typedef enum logic [1:0] {
      OTSUP_W_ARMED  = 2'h0,
      OTSUP_W_LATCH  = 2'h1,
      OTSUP_W_SUPPR  = 2'h3
   } otsup_wst_t;

endpackage : otsup_pkg

/* src/otsup_top.sv */
// Overtravel supervisor with AXI4-Lite register access
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module otsup_top
   import otsup_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        fwd_limit_in,
   input  wire logic        rev_limit_in,
   input  wire logic        servo_on,
   input  wire logic        ref_fwd,
   input  wire logic        ref_rev,
   input  wire logic        torque_ctrl,
   input  wire logic        motor_stopped,
   input  wire logic        sw_limit_fwd,
   input  wire logic        sw_limit_rev,
   input  wire logic        clear_warning_cmd,
   output var  logic        fwd_run_allow,
   output var  logic        rev_run_allow,
   output var  logic        fwd_ot,
   output var  logic        rev_ot,
   output var  logic        ccw_is_forward,
   output var  logic [1:0]  stop_action,
   output var  logic        zero_clamp,
   output var  logic [9:0]  estop_torque,
   output var  logic        ot_warning
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0]  fl_s1;        // Sync stage 1: limit fwd, rev, servo
      logic [2:0]  fl_s2;
      logic [3:0]  ot_s1;        // Sync stage 1: refs, sw limits
      logic [3:0]  ot_s2;
      logic        clr_s1;
      logic        clr_s2;
      logic        clr_d;
      logic        srv_d;
      logic [1:0]  ot_d;
      logic [31:0] cfg_sw;       // Software image of settings
      logic [31:0] cfg_act;      // Settings latched at restart
      logic [9:0]  estop;
      logic        awr;
      logic        wr;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        restart;
      logic        swclr;
      otsup_wst_t  wst;
      logic        fwd_ot;
      logic        rev_ot;
      logic        fwd_ok;
      logic        rev_ok;
      logic [1:0]  stop;
      logic        zclamp;
      logic        awrdy;
      logic        wrdy;
      logic        arrdy;
      logic        warn;
   } otsup_state_t;

   otsup_state_t st_ff;
   otsup_state_t nxt_st;

   // Decode of the post-stop mode: true means zero clamp after decel
   function automatic logic otsup_is_zclamp(input logic [3:0] d1, input logic tq);
      otsup_is_zclamp = (d1 == 4'h1) && !tq;
   endfunction : otsup_is_zclamp

   // Stop action from settings digits; torque control forbids decel
   function automatic logic [1:0] otsup_stop_of(input logic [3:0] d0, input logic [3:0] d1,
                                                 input logic tq);
      if (!tq && (d1 == 4'h1 || d1 == 4'h2)) begin
         otsup_stop_of = OTSUP_STOP_DECEL;
      end else if (d0 == 4'h2) begin
         otsup_stop_of = OTSUP_STOP_COAST;
      end else begin
         otsup_stop_of = OTSUP_STOP_DB;
      end
   endfunction : otsup_stop_of

   logic [3:0]  d_fwden;
   logic [3:0]  d_reven;
   logic [3:0]  d_stop0;
   logic [3:0]  d_stop1;
   logic [3:0]  d_warn;
   logic        lim_fwd;
   logic        lim_rev;
   logic        ot_any;
   logic        ot_dir;
   logic        ot_fs;
   logic        ot_rs;
   logic        wr_go;
   logic        rd_go;
   logic [31:0] wmask;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      // Pins and host levels pass two flip-flops first, except torque_ctrl and motor_stopped
      nxt_st.fl_s1  = {fwd_limit_in, rev_limit_in, servo_on};
      nxt_st.fl_s2  = st_ff.fl_s1;
      nxt_st.ot_s1  = {ref_fwd, ref_rev, sw_limit_fwd, sw_limit_rev};
      nxt_st.ot_s2  = st_ff.ot_s1;
      nxt_st.clr_s1 = clear_warning_cmd;
      nxt_st.clr_s2 = st_ff.clr_s1;
      nxt_st.clr_d  = st_ff.clr_s2;
      nxt_st.srv_d  = st_ff.fl_s2[0];
      nxt_st.restart = 1'b0;
      nxt_st.swclr   = 1'b0;

      // Active settings come from the restart-latched copy
      d_fwden = st_ff.cfg_act[OTSUP_CFG_FWDEN_LSB +: 4];
      d_reven = st_ff.cfg_act[OTSUP_CFG_REVEN_LSB +: 4];
      d_stop0 = st_ff.cfg_act[OTSUP_CFG_STOP_LSB +: 4];
      d_stop1 = st_ff.cfg_act[OTSUP_CFG_STOP_LSB + 4 +: 4];
      // Warning enable applies immediately
      d_warn  = st_ff.cfg_sw[OTSUP_CFG_WARN_LSB +: 4];

      // Normally closed switches: OFF (low) means overtravel
      lim_fwd = (d_fwden == OTSUP_FWD_USE_INPUT) && !st_ff.fl_s2[2];
      lim_rev = (d_reven == OTSUP_REV_USE_INPUT) && !st_ff.fl_s2[1];
      nxt_st.fwd_ot = lim_fwd;
      nxt_st.rev_ot = lim_rev;
      // Only the blocked side is prohibited; the other stays allowed
      nxt_st.fwd_ok = !lim_fwd;
      nxt_st.rev_ok = !lim_rev;

      // Stop method, post-stop mode
      nxt_st.stop   = otsup_stop_of(d_stop0, d_stop1, torque_ctrl);
      nxt_st.zclamp = (lim_fwd || lim_rev) && motor_stopped
                      && otsup_is_zclamp(d_stop1, torque_ctrl);

      // Rising overtravel per side, so a second side going over is caught
      ot_fs  = lim_fwd || st_ff.ot_s2[1];
      ot_rs  = lim_rev || st_ff.ot_s2[0];
      ot_any = ot_fs || ot_rs;
      ot_dir = (ot_fs && !st_ff.ot_d[1] && !st_ff.ot_s2[2])
            || (ot_rs && !st_ff.ot_d[0] && !st_ff.ot_s2[3]);
      nxt_st.ot_d = {ot_fs, ot_rs};

      // Warning: rising overtravel while power already on
      case (st_ff.wst)
         OTSUP_W_ARMED: begin
            if (d_warn == OTSUP_WARN_ENABLE && st_ff.fl_s2[0] && st_ff.srv_d
                && ot_dir) begin
               nxt_st.wst = OTSUP_W_LATCH;
            end
         end
         OTSUP_W_LATCH: begin
            if ((st_ff.clr_s2 && !st_ff.clr_d) || st_ff.swclr) begin
               nxt_st.wst = ot_any ? OTSUP_W_SUPPR : OTSUP_W_ARMED;
            end
         end
         OTSUP_W_SUPPR: begin
            if (!ot_any) begin
               nxt_st.wst = OTSUP_W_ARMED;
            end
         end
         default: nxt_st.wst = OTSUP_W_ARMED;
      endcase

      // AXI write channel, address and data in either order
      if (s_axi_awvalid && st_ff.awrdy) begin
         nxt_st.awr    = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_ff.wrdy) begin
         nxt_st.wr    = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      wr_go = st_ff.awr && st_ff.wr && !st_ff.bvalid;
      wmask = {{8{st_ff.wstrb[3]}}, {8{st_ff.wstrb[2]}}, {8{st_ff.wstrb[1]}}, {8{st_ff.wstrb[0]}}};
      if (wr_go) begin
         nxt_st.awr    = 1'b0;
         nxt_st.wr     = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = OTSUP_RESP_OKAY;
         case (st_ff.awaddr)
            OTSUP_ADDR_CFG: nxt_st.cfg_sw = (st_ff.cfg_sw & ~wmask) | (st_ff.wdata & wmask);
            OTSUP_ADDR_ESTOP: begin
               // Out of range torque is clipped, applied at once
               if (st_ff.wstrb[1:0] == 2'h3) begin
                  nxt_st.estop = (st_ff.wdata[15:0] > 16'(OTSUP_ESTOP_MAX))
                                 ? OTSUP_ESTOP_MAX : st_ff.wdata[9:0];
               end
            end
            OTSUP_ADDR_CTRL: begin
               if (st_ff.wstrb[0]) begin
                  nxt_st.swclr   = st_ff.wdata[OTSUP_CTRL_CLR_BIT];
                  nxt_st.restart = st_ff.wdata[OTSUP_CTRL_RST_BIT];
               end
            end
            OTSUP_ADDR_STATUS: ;
            default: nxt_st.bresp = OTSUP_RESP_SLVERR;
         endcase
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end

      // Restart loads settings that only apply after restart
      if (st_ff.restart) begin
         nxt_st.cfg_act = st_ff.cfg_sw;
      end

      // AXI read channel
      rd_go = s_axi_arvalid && st_ff.arrdy;
      if (rd_go) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp  = OTSUP_RESP_OKAY;
         nxt_st.rdata  = 32'h0000_0000;
         case (s_axi_araddr)
            OTSUP_ADDR_CFG:   nxt_st.rdata = st_ff.cfg_sw;
            OTSUP_ADDR_ESTOP: nxt_st.rdata = {22'h000000, st_ff.estop};
            OTSUP_ADDR_CTRL:  nxt_st.rdata = 32'h0000_0000;
            OTSUP_ADDR_STATUS: begin
               nxt_st.rdata[OTSUP_ST_FWD_OT] = st_ff.fwd_ot;
               nxt_st.rdata[OTSUP_ST_REV_OT] = st_ff.rev_ot;
               nxt_st.rdata[OTSUP_ST_FWD_OK] = st_ff.fwd_ok;
               nxt_st.rdata[OTSUP_ST_REV_OK] = st_ff.rev_ok;
               nxt_st.rdata[OTSUP_ST_WARN]   = (st_ff.wst == OTSUP_W_LATCH);
               nxt_st.rdata[OTSUP_ST_ZCLAMP] = st_ff.zclamp;
               nxt_st.rdata[OTSUP_ST_STOP_LSB +: 2] = st_ff.stop;
               nxt_st.rdata[OTSUP_ST_CCWFWD] = !st_ff.cfg_act[OTSUP_CFG_DIR_LSB];
            end
            default: nxt_st.rresp = OTSUP_RESP_SLVERR;
         endcase
      end
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      // Ready and warning flops
      nxt_st.awrdy = !nxt_st.awr;
      nxt_st.wrdy  = !nxt_st.wr;
      nxt_st.arrdy = !nxt_st.rvalid;
      nxt_st.warn  = (nxt_st.wst == OTSUP_W_LATCH);
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff         <= '0;
         st_ff.fl_s1   <= 3'h7;
         st_ff.fl_s2   <= 3'h7;
         st_ff.cfg_sw  <= OTSUP_CFG_RST;
         st_ff.cfg_act <= OTSUP_CFG_RST;
         st_ff.estop   <= OTSUP_ESTOP_RST;
         st_ff.fwd_ok  <= 1'b1;
         st_ff.rev_ok  <= 1'b1;
         st_ff.wst     <= OTSUP_W_ARMED;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all from flip-flops
   // ---------------------------------------------------------------
   assign s_axi_awready  = st_ff.awrdy;
   assign s_axi_wready   = st_ff.wrdy;
   assign s_axi_bvalid   = st_ff.bvalid;
   assign s_axi_bresp    = st_ff.bresp;
   assign s_axi_arready  = st_ff.arrdy;
   assign s_axi_rvalid   = st_ff.rvalid;
   assign s_axi_rdata    = st_ff.rdata;
   assign s_axi_rresp    = st_ff.rresp;
   assign fwd_run_allow  = st_ff.fwd_ok;
   assign rev_run_allow  = st_ff.rev_ok;
   assign fwd_ot         = st_ff.fwd_ot;
   assign rev_ot         = st_ff.rev_ot;
   // Direction mapping only; no output polarity depends on it
   assign ccw_is_forward = !st_ff.cfg_act[OTSUP_CFG_DIR_LSB];
   assign stop_action    = st_ff.stop;
   assign zero_clamp     = st_ff.zclamp;
   assign estop_torque   = st_ff.estop;
   assign ot_warning     = st_ff.warn;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   AST_FWD_OT: assert property (@(posedge aclk) disable iff (!aresetn)
      (aresetn && !fwd_limit_in && st_ff.cfg_act[7:4] == OTSUP_FWD_USE_INPUT)[*3] |=> fwd_ot)
      else $error("forward overtravel not flagged");
   AST_REV_OT: assert property (@(posedge aclk) disable iff (!aresetn)
      (aresetn && !rev_limit_in && st_ff.cfg_act[11:8] == OTSUP_REV_USE_INPUT)[*3] |=> rev_ot)
      else $error("reverse overtravel not flagged");
   AST_OPPOSITE: assert property (@(posedge aclk) disable iff (!aresetn)
      fwd_ot |-> rev_run_allow == !rev_ot)
      else $error("opposite direction blocked");
   AST_FWD_IGN: assert property (@(posedge aclk) disable iff (!aresetn)
      st_ff.cfg_act[7:4] == OTSUP_LIMIT_IGNORE |=> !fwd_ot)
      else $error("ignored forward limit flagged");
   AST_TQ_NODECEL: assert property (@(posedge aclk) disable iff (!aresetn)
      torque_ctrl |=> stop_action != OTSUP_STOP_DECEL)
      else $error("decel stop under torque control");
   AST_ESTOP_MAX: assert property (@(posedge aclk) disable iff (!aresetn)
      estop_torque <= OTSUP_ESTOP_MAX)
      else $error("estop torque out of range");
   AST_NO_WARN_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_ff.fl_s2[0] && !ot_warning |=> !ot_warning)
      else $error("warning raised with power off");
   AST_WARN_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      ot_warning && !(st_ff.clr_s2 && !st_ff.clr_d) && !st_ff.swclr |=> ot_warning)
      else $error("warning dropped without clear");
   AST_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
      ot_warning && st_ff.clr_s2 && !st_ff.clr_d |=> !ot_warning)
      else $error("clear not honoured");
   AST_WEN: assert property (@(posedge aclk) disable iff (!aresetn)
      !ot_warning && st_ff.cfg_sw[OTSUP_CFG_WARN_LSB +: 4] != OTSUP_WARN_ENABLE |=> !ot_warning)
      else $error("warning with detection disabled");

   COV_WARN:  cover property (@(posedge aclk) disable iff (!aresetn) !ot_warning ##1 ot_warning);
   COV_SUPPR: cover property (@(posedge aclk) disable iff (!aresetn) st_ff.wst == OTSUP_W_SUPPR);
   COV_ZCL:   cover property (@(posedge aclk) disable iff (!aresetn) zero_clamp);

endmodule : otsup_top
`default_nettype wire

/* tb/otsup_host_model.sv */
// Host controller and machine limit switch model for the overtravel supervisor
`timescale 1ns/1ns
`default_nettype none
module otsup_host_model (
   input  wire logic aclk,
   output var  logic fwd_limit_in,
   output var  logic rev_limit_in,
   output var  logic servo_on,
   output var  logic ref_fwd,
   output var  logic ref_rev,
   output var  logic sw_limit_fwd,
   output var  logic sw_limit_rev,
   output var  logic clear_warning_cmd
);
   // ----------------------------------------------------------------
   // Field side
   // ----------------------------------------------------------------
   // Normally closed switches idle high, so a broken wire reads as overtravel
   initial begin
      {fwd_limit_in, rev_limit_in} = 2'h3;
      {servo_on, ref_fwd, ref_rev, sw_limit_fwd, sw_limit_rev, clear_warning_cmd} = 6'h00;
   end
   // Source 0 fwd, 1 rev, 2 soft fwd, 3 soft rev; act opens the switch
   task automatic set_src(input int k, input logic act);
      case (k)
         0: fwd_limit_in <= ~act;
         1: rev_limit_in <= ~act;
         2: sw_limit_fwd <= act;
         default: sw_limit_rev <= act;
      endcase
   endtask : set_src
   // Brief overtravel, just long enough to pass the input synchroniser
   task automatic pulse(input int k, input int n);
      @(posedge aclk);
      set_src(k, 1'b1);
      repeat (n) @(posedge aclk);
      set_src(k, 1'b0);
   endtask : pulse
   // Servo power and reference direction as levels
   task automatic drive(input logic s, input logic f, input logic r);
      @(posedge aclk);
      servo_on <= s;
      ref_fwd  <= f;
      ref_rev  <= r;
   endtask : drive
   // Clear command held several cycles so its rising edge is seen
   task automatic clear();
      @(posedge aclk);
      clear_warning_cmd <= 1'b1;
      repeat (4) @(posedge aclk);
      clear_warning_cmd <= 1'b0;
   endtask : clear
endmodule : otsup_host_model
`default_nettype wire

/* tb/overtravel_supervisor_test.sv */
// Self-checking testbench for the overtravel supervisor
`timescale 1ns/1ns
`default_nettype none
module overtravel_supervisor_test import otsup_pkg::*;;
   typedef struct {logic [31:0] v; logic [31:0] m; logic [1:0] r;} otsup_exp_t;
   localparam logic [31:0] BASE = {20'h0, OTSUP_REV_USE_INPUT, OTSUP_FWD_USE_INPUT, 4'h0};
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, v;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, stop_action;
   logic        fwd_limit_in, rev_limit_in, servo_on, ref_fwd, ref_rev, torque_ctrl, motor_stopped;
   logic        sw_limit_fwd, sw_limit_rev, clear_warning_cmd, fwd_run_allow, rev_run_allow;
   logic        fwd_ot, rev_ot, ccw_is_forward, zero_clamp, ot_warning;
   logic [9:0]  estop_torque;
   logic [31:0] stc [6] = '{32'h210, 32'h1210, 32'h2210, 32'h10210, 32'h20210, 32'h12210};
   logic [3:0]  stx [6] = '{4'h0, 4'h0, 4'h1, 4'h7, 4'h3, 4'h9};
   logic [5:0]  wt  [7] = '{6'h38, 6'h19, 6'h31, 6'h30, 6'h37, 6'h16, 6'h00};
   otsup_exp_t  rq [$];
   logic [1:0]  bq [$];
   otsup_exp_t  e;
   int          error_cnt = 0;
   int          compares  = 0;

   otsup_top otsup_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fwd_limit_in,
      .rev_limit_in, .servo_on, .ref_fwd, .ref_rev, .torque_ctrl, .motor_stopped, .sw_limit_fwd, .sw_limit_rev,
      .clear_warning_cmd, .fwd_run_allow, .rev_run_allow, .fwd_ot, .rev_ot, .ccw_is_forward, .stop_action,
      .zero_clamp, .estop_torque, .ot_warning);
   otsup_host_model otsup_host_model_inst (.aclk, .fwd_limit_in, .rev_limit_in, .servo_on, .ref_fwd,
      .ref_rev, .sw_limit_fwd, .sw_limit_rev, .clear_warning_cmd);

   // ----------------------------------------------------------------
   // Bus tasks and result checking
   // ----------------------------------------------------------------
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bq.push_back(er);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [31:0] em, input logic [1:0] er);
      rq.push_back('{ev & em, em, er});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   // Status read after the synchroniser and flag registers have settled
   task automatic st(input logic [31:0] ev, input logic [31:0] em);
      repeat (6) @(posedge aclk);
      rd(OTSUP_ADDR_STATUS, ev, em, OTSUP_RESP_OKAY);
      // Pins carry the same flags as the status word
      chk({2'h0, em & {19'h0, ccw_is_forward, 2'h0, stop_action, 2'h0, zero_clamp, ot_warning, rev_run_allow,
         fwd_run_allow, rev_ot, fwd_ot}}, {2'h0, ev & em});
   endtask : st
   // Settings reach the active copy only through restart
   task automatic cfg(input logic [31:0] d);
      wr(OTSUP_ADDR_CFG, d, OTSUP_RESP_OKAY);
      wr(OTSUP_ADDR_CTRL, 32'h0000_0002, OTSUP_RESP_OKAY);
   endtask : cfg
   task automatic fin(input string n);
      $display("test %s done", n);
   endtask : fin
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   // Oldest note is compared against each completed response
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         e = rq.pop_front();
         chk({s_axi_rresp, s_axi_rdata & e.m}, {e.r, e.v});
      end
      if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
   end

   // ----------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ----------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // Whole run needs a few hundred cycles; this cuts a hung handshake
   initial begin
      repeat (30000) @(posedge aclk);
      error_cnt++;
      close_out();
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
      {torque_ctrl, motor_stopped} = 2'h0;
      void'($urandom(67277));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OTSUP_ADDR_CFG, BASE, 32'hffff_ffff, OTSUP_RESP_OKAY);
      rd(OTSUP_ADDR_STATUS, 32'h0000_100c, 32'h0000_133f, OTSUP_RESP_OKAY);
      rd(8'h10, 32'h0, 32'hffff_ffff, OTSUP_RESP_SLVERR);
      rd(OTSUP_ADDR_ESTOP, {22'h0, OTSUP_ESTOP_RST}, 32'h0000_03ff, OTSUP_RESP_OKAY);
      wr(8'h14, 32'h0, OTSUP_RESP_SLVERR);
      fin("reset");
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 32'h0000_0320 : (i == 1) ? $urandom_range(800) : (i == 2) ? 32'h0 : 32'h0000_03ff;
         wr(OTSUP_ADDR_ESTOP, v, OTSUP_RESP_OKAY);
         rd(OTSUP_ADDR_ESTOP, (v > 32'h320) ? 32'h320 : v, 32'h0000_03ff, OTSUP_RESP_OKAY);
      end
      fin("estop");
      otsup_host_model_inst.set_src(0, 1'b1);
      st(32'h0000_0009, 32'h0000_000f);
      otsup_host_model_inst.set_src(0, 1'b0);
      otsup_host_model_inst.set_src(1, 1'b1);
      st(32'h0000_0006, 32'h0000_000f);
      otsup_host_model_inst.set_src(1, 1'b0);
      wr(OTSUP_ADDR_CFG, BASE ^ 32'h0000_0091, OTSUP_RESP_OKAY);
      otsup_host_model_inst.set_src(0, 1'b1);
      st(32'h0000_1009, 32'h0000_100f);
      wr(OTSUP_ADDR_CTRL, 32'h0000_0002, OTSUP_RESP_OKAY);
      st(32'h0000_000c, 32'h0000_100f);
      cfg(BASE ^ 32'h0000_0a00);
      otsup_host_model_inst.set_src(1, 1'b1);
      st(32'h0000_1009, 32'h0000_100f);
      otsup_host_model_inst.set_src(1, 1'b0);
      fin("limits");
      motor_stopped <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         torque_ctrl <= stx[i][3];
         cfg(stc[i]);
         st({22'h0, stx[i][1:0], 2'h0, stx[i][2], 5'h0}, 32'h0000_0320);
      end
      otsup_host_model_inst.set_src(0, 1'b0);
      {torque_ctrl, motor_stopped} <= 2'h0;
      fin("stop");
      cfg(BASE | 32'h0010_0000);
      for (int i = 0; i < 7; i++) begin
         otsup_host_model_inst.drive(wt[i][4], wt[i][3], wt[i][2]);
         repeat (4) @(posedge aclk);
         otsup_host_model_inst.pulse(int'(wt[i][1:0]), 3);
         st({27'h0, wt[i][5], 4'h0}, 32'h0000_0010);
         otsup_host_model_inst.clear();
         st(32'h0, 32'h0000_0010);
      end
      otsup_host_model_inst.set_src(0, 1'b1);
      repeat (4) @(posedge aclk);
      otsup_host_model_inst.drive(1'b1, 1'b0, 1'b0);
      st(32'h0, 32'h0000_0010);
      otsup_host_model_inst.set_src(1, 1'b1);
      st(32'h0000_0010, 32'h0000_0010);
      wr(OTSUP_ADDR_CTRL, 32'h0000_0001, OTSUP_RESP_OKAY);
      st(32'h0, 32'h0000_0010);
      otsup_host_model_inst.set_src(0, 1'b0);
      otsup_host_model_inst.set_src(1, 1'b0);
      otsup_host_model_inst.pulse(0, 3);
      st(32'h0000_0010, 32'h0000_0010);
      otsup_host_model_inst.clear();
      wr(OTSUP_ADDR_CFG, BASE, OTSUP_RESP_OKAY);
      otsup_host_model_inst.pulse(0, 3);
      st(32'h0, 32'h0000_0010);
      fin("warning");
      close_out();
   end
endmodule : overtravel_supervisor_test
`default_nettype wire
